// ===== src/plbs_plb_slave.sv
// plb slave port: window decode, single-beat answers, axi4-lite registers
`timescale 1ns/10ps
`include "plbs_cfg.svh"

// Behaviour
// - address path is 32 bits wide, nothing else supported.
// - data paths are 32 bits wide with four byte enables.
// - bursts are not supported; burst support parameter must be zero.
// - size answer is always 00, a 32-bit slave.
// - rearbitrate output is always zero.
// - write and read burst terminate outputs are always zero.
// - read word address output is always zero.
// - per-master write error, read error and interrupt outputs stay zero.
// - secondary, abort, lock, msize, burst, pending and priority inputs ignored.
// - upper address bus unused; decode uses the primary address only.
module plbs_plb_slave #(
    parameter logic [31:0] window_base_param      = 32'h0001_0000,
    parameter logic [31:0] window_top_param       = 32'h0001_FFFF,
    parameter int          master_count_param     = 1,
    parameter int          master_id_width_param  = 1,
    parameter int          burst_support_param    = 0,
    parameter int          bus_clock_period_param = 40000
) (
    input  wire logic                              clk,
    input  wire logic                              resetn,
    input  wire plbs_pkg::plbs_plb_req_t           plb_req,
    input  wire logic [master_id_width_param-1:0]  plb_masterid,
    output plbs_pkg::plbs_plb_rsp_t                plb_rsp,
    output logic [master_count_param-1:0]          sl_mbusy,
    output logic [master_count_param-1:0]          sl_mwrerr,
    output logic [master_count_param-1:0]          sl_mrderr,
    output logic [master_count_param-1:0]          sl_mirq,
    output logic                                   host_interrupt_out,
    input  wire logic [7:0]                        s_axi_awaddr,
    input  wire logic                              s_axi_awvalid,
    output logic                                   s_axi_awready,
    input  wire logic [31:0]                       s_axi_wdata,
    input  wire logic [3:0]                        s_axi_wstrb,
    input  wire logic                              s_axi_wvalid,
    output logic                                   s_axi_wready,
    output logic [1:0]                             s_axi_bresp,
    output logic                                   s_axi_bvalid,
    input  wire logic                              s_axi_bready,
    input  wire logic [7:0]                        s_axi_araddr,
    input  wire logic                              s_axi_arvalid,
    output logic                                   s_axi_arready,
    output logic [31:0]                            s_axi_rdata,
    output logic [1:0]                             s_axi_rresp,
    output logic                                   s_axi_rvalid,
    input  wire logic                              s_axi_rready,
    input  wire logic                              link_clk,
    input  wire logic                              link_resetn,
    input  wire logic                              core_irq,
    output logic                                   core_req_valid,
    output plbs_pkg::plbs_core_req_t               core_req,
    input  wire logic                              core_req_ready,
    input  wire logic [`PLBS_DWIDTH-1:0]           core_rdata
);
    // ------------------------------------------------------------
    // configuration checks, visible in the status word
    // ------------------------------------------------------------
    localparam logic CFG_BURST_ERR = (burst_support_param != 0);
    localparam logic CFG_CLK_ERR =
        (bus_clock_period_param > `PLBS_CLK_PERIOD_MAX_PS);
    localparam logic CFG_WIN_ERR = (({1'b0, window_top_param} - {1'b0, window_base_param}
        + `PLBS_ONE33) < `PLBS_WINDOW_MIN_BYTES);

    plbs_pkg::plbs_state_t    state_ff, nxt_state;
    plbs_pkg::plbs_core_req_t xfer_ff, nxt_xfer;
    logic                     addrack_ff, nxt_addrack;
    logic                     wrack_ff, nxt_wrack;
    logic                     rdack_ff, nxt_rdack;
    logic [31:0]              rddbus_ff, nxt_rddbus;
    logic [31:0]              count_ff, nxt_count;
    logic [31:0]              last_ff, nxt_last;
    logic [master_count_param-1:0] mbusy_ff, nxt_mbusy;
    logic [2:0]               viol_ff, nxt_viol, viol_set, viol_clr;
    logic [1:0]               irq_sync_ff, nxt_irq_sync;
    logic                     hit, accept, mid_ok, src_done;
    logic [31:0]              src_rdata, status;

    // ------------------------------------------------------------
    // interrupt crossing
    // ------------------------------------------------------------
    always_comb begin
        nxt_irq_sync = {irq_sync_ff[0], core_irq};
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_sync_ff <= 2'h0;
        end else begin
            irq_sync_ff <= nxt_irq_sync;
        end
    end

    assign host_interrupt_out = irq_sync_ff[1];

    // ------------------------------------------------------------
    // request decode
    // ------------------------------------------------------------
    // the upper address bus and the secondary, lock, abort, burst and
    // priority inputs of plb_req are left unread on purpose
    assign hit = (plb_req.abus >= window_base_param)
              && (plb_req.abus <= window_top_param);
    logic ctrl_en_ff, nxt_ctrl_en;
    assign accept = (state_ff == plbs_pkg::PLBS_IDLE) && plb_req.pavalid && hit
                 && ctrl_en_ff;
    assign mid_ok = (32'(plb_masterid) < master_count_param);

    // single-beat service even when the qualifiers break the contract;
    // the breach is only recorded, the access is not refused
    assign viol_set = accept ? {plb_req.tattribute != `PLBS_TATTR_NONE,
                                plb_req.ttype != `PLBS_TYPE_MEM,
                                plb_req.size != `PLBS_SIZE_SINGLE}
                             : 3'h0;

    // ------------------------------------------------------------
    // transfer sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state   = state_ff;
        nxt_xfer    = xfer_ff;
        nxt_addrack = 1'b0;
        nxt_wrack   = 1'b0;
        nxt_rdack   = 1'b0;
        nxt_rddbus  = 32'h0000_0000;
        nxt_count   = count_ff;
        nxt_last    = last_ff;
        unique case (state_ff)
            plbs_pkg::PLBS_IDLE: begin
                if (accept) begin
                    nxt_addrack = 1'b1;
                    nxt_xfer    = '{addr: plb_req.abus, wdata: plb_req.wrdbus,
                                    be: plb_req.be, rnw: plb_req.rnw};
                    nxt_last    = plb_req.abus;
                    nxt_state   = plbs_pkg::PLBS_ADDR_ACK;
                end
            end
            plbs_pkg::PLBS_ADDR_ACK: begin
                nxt_state = plbs_pkg::PLBS_CORE_WAIT;
            end
            plbs_pkg::PLBS_CORE_WAIT: begin
                if (src_done) begin
                    if (xfer_ff.rnw) begin
                        nxt_rdack  = 1'b1;
                        nxt_rddbus = src_rdata;
                    end else begin
                        nxt_wrack = 1'b1;
                    end
                    nxt_state = plbs_pkg::PLBS_COMPLETE;
                end
            end
            plbs_pkg::PLBS_COMPLETE: begin
                nxt_count = count_ff + 32'h0000_0001;
                nxt_state = plbs_pkg::PLBS_IDLE;
            end
        endcase
    end

    for (genvar i = 0; i < master_count_param; i++) begin : g_busy
        assign nxt_mbusy[i] = (accept && mid_ok && (32'(plb_masterid) == i)) ? 1'b1
                            : (state_ff == plbs_pkg::PLBS_COMPLETE) ? 1'b0
                            : mbusy_ff[i];
    end

    // set wins over a software clear in the same cycle
    assign nxt_viol = (viol_ff & ~viol_clr) | viol_set;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_ff   <= plbs_pkg::PLBS_IDLE;
            xfer_ff    <= '0;
            addrack_ff <= 1'b0;
            wrack_ff   <= 1'b0;
            rdack_ff   <= 1'b0;
            rddbus_ff  <= 32'h0000_0000;
            count_ff   <= 32'h0000_0000;
            last_ff    <= 32'h0000_0000;
            mbusy_ff   <= '0;
            viol_ff    <= 3'h0;
        end else begin
            state_ff   <= nxt_state;
            xfer_ff    <= nxt_xfer;
            addrack_ff <= nxt_addrack;
            wrack_ff   <= nxt_wrack;
            rdack_ff   <= nxt_rdack;
            rddbus_ff  <= nxt_rddbus;
            count_ff   <= nxt_count;
            last_ff    <= nxt_last;
            mbusy_ff   <= nxt_mbusy;
            viol_ff    <= nxt_viol;
        end
    end

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    always_comb begin
        plb_rsp.addrack     = addrack_ff;
        plb_rsp.ssize       = `PLBS_SSIZE_32;
        plb_rsp.sl_wait     = 1'b0;
        plb_rsp.rearbitrate = 1'b0;
        plb_rsp.wrdack      = wrack_ff;
        plb_rsp.wrcomp      = wrack_ff;
        plb_rsp.wrbterm     = 1'b0;
        plb_rsp.rddbus      = rddbus_ff;
        plb_rsp.rdwdaddr    = 4'h0;
        plb_rsp.rddack      = rdack_ff;
        plb_rsp.rdcomp      = rdack_ff;
        plb_rsp.rdbterm     = 1'b0;
    end

    assign sl_mbusy  = mbusy_ff;
    assign sl_mwrerr = '0;
    assign sl_mrderr = '0;
    assign sl_mirq   = '0;

    // ------------------------------------------------------------
    // crossing to the core clock
    // ------------------------------------------------------------
    plbs_xfer_sync u_sync (
        .src_clk    (clk),
        .src_resetn (resetn),
        .src_start  (state_ff == plbs_pkg::PLBS_ADDR_ACK),
        .src_word   (xfer_ff),
        .src_done   (src_done),
        .src_rdata  (src_rdata),
        .dst_clk    (link_clk),
        .dst_resetn (link_resetn),
        .dst_valid  (core_req_valid),
        .dst_word   (core_req),
        .dst_ready  (core_req_ready),
        .dst_rdata  (core_rdata)
    );

    // ------------------------------------------------------------
    // register write channel
    // ------------------------------------------------------------
    logic       aw_held_ff, nxt_aw_held, w_held_ff, nxt_w_held;
    logic       bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic [7:0] awaddr_ff, nxt_awaddr;
    logic [31:0] wdata_ff, nxt_wdata;
    logic [3:0] wstrb_ff, nxt_wstrb;
    logic       do_write;

    assign s_axi_awready = !aw_held_ff && !bvalid_ff;
    assign s_axi_wready  = !w_held_ff && !bvalid_ff;
    assign do_write      = aw_held_ff && w_held_ff;
    assign viol_clr = (do_write && (awaddr_ff == `PLBS_REG_STATUS) && wstrb_ff[1])
                    ? wdata_ff[`PLBS_ST_VIOL_HI:`PLBS_ST_VIOL_LO] : 3'h0;

    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_w_held  = w_held_ff;
        nxt_awaddr  = awaddr_ff;
        nxt_wdata   = wdata_ff;
        nxt_wstrb   = wstrb_ff;
        nxt_bvalid  = bvalid_ff && !s_axi_bready;
        nxt_bresp   = bresp_ff;
        nxt_ctrl_en = ctrl_en_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_held = 1'b1;
            nxt_awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_held = 1'b1;
            nxt_wdata  = s_axi_wdata;
            nxt_wstrb  = s_axi_wstrb;
        end
        if (do_write) begin
            nxt_aw_held = 1'b0;
            nxt_w_held  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = `PLBS_RESP_OKAY;
            unique case (awaddr_ff)
                `PLBS_REG_CTRL: begin
                    if (wstrb_ff[0]) begin
                        nxt_ctrl_en = wdata_ff[0];
                    end
                end
                `PLBS_REG_STATUS, `PLBS_REG_COUNT, `PLBS_REG_LAST: begin
                end
                default: begin
                    nxt_bresp = `PLBS_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            awaddr_ff  <= 8'h00;
            wdata_ff   <= 32'h0000_0000;
            wstrb_ff   <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `PLBS_RESP_OKAY;
            ctrl_en_ff <= `PLBS_CTRL_RESET;
        end else begin
            aw_held_ff <= nxt_aw_held;
            w_held_ff  <= nxt_w_held;
            awaddr_ff  <= nxt_awaddr;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
            ctrl_en_ff <= nxt_ctrl_en;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // ------------------------------------------------------------
    // register read channel
    // ------------------------------------------------------------
    logic        rvalid_ff, nxt_rvalid;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [1:0]  rresp_ff, nxt_rresp;

    always_comb begin
        status = 32'h0000_0000;
        status[`PLBS_ST_BUSY]      = (state_ff != plbs_pkg::PLBS_IDLE);
        status[`PLBS_ST_IRQ]       = irq_sync_ff[1];
        status[`PLBS_ST_CFG_BURST] = CFG_BURST_ERR;
        status[`PLBS_ST_CFG_CLK]   = CFG_CLK_ERR;
        status[`PLBS_ST_CFG_WIN]   = CFG_WIN_ERR;
        status[`PLBS_ST_VIOL_HI:`PLBS_ST_VIOL_LO] = viol_ff;
    end

    assign s_axi_arready = !rvalid_ff;

    always_comb begin
        nxt_rvalid = rvalid_ff && !s_axi_rready;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rresp  = `PLBS_RESP_OKAY;
            unique case (s_axi_araddr)
                `PLBS_REG_CTRL:   nxt_rdata = {31'h0000_0000, ctrl_en_ff};
                `PLBS_REG_STATUS: nxt_rdata = status;
                `PLBS_REG_COUNT:  nxt_rdata = count_ff;
                `PLBS_REG_LAST:   nxt_rdata = last_ff;
                default: begin
                    nxt_rdata = 32'h0000_0000;
                    nxt_rresp = `PLBS_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `PLBS_RESP_OKAY;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata  = rdata_ff;
    assign s_axi_rresp  = rresp_ff;
endmodule

// ===== src/plbs_cfg.svh
// constants of the plb slave port: widths, fixed answers, register map
`ifndef PLBS_CFG_SVH
`define PLBS_CFG_SVH

`define PLBS_AWIDTH 32
`define PLBS_DWIDTH 32
`define PLBS_BEWIDTH (`PLBS_DWIDTH/8)
`define PLBS_CLK_PERIOD_MAX_PS 40000
`define PLBS_WINDOW_MIN_BYTES 33'h0_0001_0000
`define PLBS_ONE33 33'h0_0000_0001
`define PLBS_SSIZE_32 2'h0
`define PLBS_SIZE_SINGLE 4'h0
`define PLBS_TYPE_MEM 3'h0
`define PLBS_TATTR_NONE 16'h0000

`define PLBS_REG_CTRL 8'h00
`define PLBS_REG_STATUS 8'h04
`define PLBS_REG_COUNT 8'h08
`define PLBS_REG_LAST 8'h0C
`define PLBS_CTRL_RESET 1'h1
`define PLBS_ST_BUSY 0
`define PLBS_ST_IRQ 1
`define PLBS_ST_CFG_BURST 4
`define PLBS_ST_CFG_CLK 5
`define PLBS_ST_CFG_WIN 6
`define PLBS_ST_VIOL_LO 8
`define PLBS_ST_VIOL_HI 10
`define PLBS_RESP_OKAY 2'h0
`define PLBS_RESP_SLVERR 2'h2

`endif

// ===== src/plbs_pkg.sv
// types of the plb slave port
`include "plbs_cfg.svh"
package plbs_pkg;
    // bit [31] of abus is bus bit 0 (the bus numbers big-endian)
    typedef struct packed {
        logic [`PLBS_AWIDTH-1:0]  abus;
        logic [`PLBS_AWIDTH-1:0]  uabus;
        logic                     pavalid;
        logic                     savalid;
        logic                     rdprim;
        logic                     wrprim;
        logic                     abort;
        logic                     buslock;
        logic                     rnw;
        logic [`PLBS_BEWIDTH-1:0] be;
        logic [1:0]               msize;
        logic [3:0]               size;
        logic [2:0]               ttype;
        logic                     lockerr;
        logic [`PLBS_DWIDTH-1:0]  wrdbus;
        logic                     wrburst;
        logic                     rdburst;
        logic                     wrpendreq;
        logic                     rdpendreq;
        logic [1:0]               wrpendpri;
        logic [1:0]               rdpendpri;
        logic [1:0]               reqpri;
        logic [15:0]              tattribute;
    } plbs_plb_req_t;

    typedef struct packed {
        logic                    addrack;
        logic [1:0]              ssize;
        logic                    sl_wait;
        logic                    rearbitrate;
        logic                    wrdack;
        logic                    wrcomp;
        logic                    wrbterm;
        logic [`PLBS_DWIDTH-1:0] rddbus;
        logic [3:0]              rdwdaddr;
        logic                    rddack;
        logic                    rdcomp;
        logic                    rdbterm;
    } plbs_plb_rsp_t;

    typedef struct packed {
        logic [`PLBS_AWIDTH-1:0]  addr;
        logic [`PLBS_DWIDTH-1:0]  wdata;
        logic [`PLBS_BEWIDTH-1:0] be;
        logic                     rnw;
    } plbs_core_req_t;

    typedef enum logic [1:0] {
        PLBS_IDLE,
        PLBS_ADDR_ACK,
        PLBS_CORE_WAIT,
        PLBS_COMPLETE
    } plbs_state_t;
endpackage

// ===== src/plbs_xfer_sync.sv
// toggle handshake carrying one access and its read data between two clocks
`timescale 1ns/10ps
`include "plbs_cfg.svh"
module plbs_xfer_sync (
    input  wire logic                     src_clk,
    input  wire logic                     src_resetn,
    input  wire logic                     src_start,
    input  wire plbs_pkg::plbs_core_req_t src_word,
    output logic                          src_done,
    output logic [`PLBS_DWIDTH-1:0]       src_rdata,
    input  wire logic                     dst_clk,
    input  wire logic                     dst_resetn,
    output logic                          dst_valid,
    output plbs_pkg::plbs_core_req_t      dst_word,
    input  wire logic                     dst_ready,
    input  wire logic [`PLBS_DWIDTH-1:0]  dst_rdata
);
    // src_word must stay still from src_start until src_done
    logic                     req_tgl_ff, nxt_req_tgl;
    logic [2:0]               ack_sync_ff, nxt_ack_sync;
    logic                     done_ff, nxt_done;
    logic [`PLBS_DWIDTH-1:0]  rdata_ff, nxt_rdata;
    logic [2:0]               req_sync_ff, nxt_req_sync;
    logic                     valid_ff, nxt_valid;
    plbs_pkg::plbs_core_req_t word_ff, nxt_word;
    logic                     ack_tgl_ff, nxt_ack_tgl;
    logic [`PLBS_DWIDTH-1:0]  hold_ff, nxt_hold;

    // ------------------------------------------------------------
    // source side
    // ------------------------------------------------------------
    always_comb begin
        nxt_req_tgl  = req_tgl_ff ^ src_start;
        nxt_ack_sync = {ack_sync_ff[1:0], ack_tgl_ff};
        nxt_done     = ack_sync_ff[2] ^ ack_sync_ff[1];
        // hold_ff is stable once the toggle has been seen here
        nxt_rdata    = nxt_done ? hold_ff : rdata_ff;
    end

    always_ff @(posedge src_clk) begin
        if (!src_resetn) begin
            req_tgl_ff  <= 1'b0;
            ack_sync_ff <= 3'h0;
            done_ff     <= 1'b0;
            rdata_ff    <= 32'h0000_0000;
        end else begin
            req_tgl_ff  <= nxt_req_tgl;
            ack_sync_ff <= nxt_ack_sync;
            done_ff     <= nxt_done;
            rdata_ff    <= nxt_rdata;
        end
    end

    assign src_done  = done_ff;
    assign src_rdata = rdata_ff;

    // ------------------------------------------------------------
    // destination side
    // ------------------------------------------------------------
    always_comb begin
        nxt_req_sync = {req_sync_ff[1:0], req_tgl_ff};
        nxt_valid    = valid_ff;
        nxt_word     = word_ff;
        nxt_ack_tgl  = ack_tgl_ff;
        nxt_hold     = hold_ff;
        if (req_sync_ff[2] ^ req_sync_ff[1]) begin
            nxt_valid = 1'b1;
            nxt_word  = src_word;
        end else if (valid_ff && dst_ready) begin
            nxt_valid   = 1'b0;
            nxt_hold    = dst_rdata;
            nxt_ack_tgl = ~ack_tgl_ff;
        end
    end

    always_ff @(posedge dst_clk) begin
        if (!dst_resetn) begin
            req_sync_ff <= 3'h0;
            valid_ff    <= 1'b0;
            word_ff     <= '0;
            ack_tgl_ff  <= 1'b0;
            hold_ff     <= 32'h0000_0000;
        end else begin
            req_sync_ff <= nxt_req_sync;
            valid_ff    <= nxt_valid;
            word_ff     <= nxt_word;
            ack_tgl_ff  <= nxt_ack_tgl;
            hold_ff     <= nxt_hold;
        end
    end

    assign dst_valid = valid_ff;
    assign dst_word  = word_ff;
endmodule

// ===== sim/plbs_core_model.sv
// stand-in for the controller core on the link clock
`timescale 1ns/10ps
module plbs_core_model (
    input  wire logic                     link_clk,
    input  wire logic [3:0]               slow,
    input  wire logic                     core_req_valid,
    input  wire plbs_pkg::plbs_core_req_t core_req,
    output logic                          core_req_ready,
    output logic [31:0]                   core_rdata
);
    logic [3:0]  wait_ff = 4'h0;
    logic [31:0] pat_ff  = 32'h0000_0000;
    assign core_req_ready = core_req_valid && wait_ff >= slow;
    // idle data toggles so a late sample never passes by luck
    assign core_rdata = core_req_ready ? ~core_req.addr : pat_ff;
    always_ff @(posedge link_clk) begin
        pat_ff <= ~pat_ff;
        wait_ff <= core_req_valid && !core_req_ready ? wait_ff + 4'h1 : 4'h0;
    end
endmodule

// ===== sim/plbs_plb_slave_properties.sv
// checker of fixed answers and ack order at the plb port
`timescale 1ns/10ps
module plbs_props #(parameter int master_count_param = 1) (
    input wire logic                          clk,
    input wire logic                          resetn,
    input wire plbs_pkg::plbs_plb_req_t       plb_req,
    input wire plbs_pkg::plbs_plb_rsp_t       plb_rsp,
    input wire logic [master_count_param-1:0] sl_mbusy,
    input wire logic [master_count_param-1:0] sl_mwrerr,
    input wire logic [master_count_param-1:0] sl_mrderr,
    input wire logic [master_count_param-1:0] sl_mirq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_ssize; plb_rsp.ssize == 2'h0; endproperty
    a_ssize: assert property (p_ssize) else $error("ssize moved");
    property p_rearb; !plb_rsp.rearbitrate; endproperty
    a_rearb: assert property (p_rearb) else $error("rearbitrate");
    property p_bterm; !(plb_rsp.wrbterm || plb_rsp.rdbterm); endproperty
    a_bterm: assert property (p_bterm) else $error("burst term");
    property p_wdad; plb_rsp.rdwdaddr == 4'h0; endproperty
    a_wdad: assert property (p_wdad) else $error("rdwdaddr");
    property p_err; (sl_mwrerr | sl_mrderr | sl_mirq) == '0; endproperty
    a_err: assert property (p_err) else $error("err or irq");
    property p_comp;
        {plb_rsp.wrdack, plb_rsp.rddack} == {plb_rsp.wrcomp, plb_rsp.rdcomp};
    endproperty
    a_comp: assert property (p_comp) else $error("ack without complete");
    property p_ack; plb_rsp.addrack |-> $past(plb_req.pavalid) && sl_mbusy != '0; endproperty
    a_ack: assert property (p_ack) else $error("stray addrack");
    property p_done; plb_rsp.wrcomp || plb_rsp.rdcomp |=> sl_mbusy == '0; endproperty
    a_done: assert property (p_done) else $error("busy stuck");
    c_wr: cover property (plb_rsp.wrcomp);
    c_rd: cover property (plb_rsp.rdcomp);
    c_ack: cover property (plb_rsp.addrack);
endmodule
bind plbs_plb_slave plbs_props #(.master_count_param(master_count_param)) u_chk (.*);

// ===== sim/plb_slave_process_data_port_test.sv
// self-checking bench of the plb slave port
`timescale 1ns/10ps
module plb_slave_process_data_port_test;
    typedef struct packed {logic rw; logic [31:0] a; logic [3:0] sz; logic ign, ack;} plbs_row_t;
    logic clk = 0, link_clk = 0, resetn = 0, link_resetn = 0, core_irq = 0;
    logic [3:0] slow = 4'h0, s_axi_wstrb = 4'hF;
    logic [0:0] plb_masterid = 1'b0, sl_mbusy, sl_mwrerr, sl_mrderr, sl_mirq;
    plbs_pkg::plbs_plb_req_t  plb_req = '0;
    plbs_pkg::plbs_plb_rsp_t  plb_rsp;
    plbs_pkg::plbs_core_req_t core_req;
    logic host_interrupt_out, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, core_req_valid, core_req_ready;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, core_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int errors = 0, num_checks = 0;
    plbs_row_t rows [6] = '{'{0, 32'h0001_0000, 0, 0, 1}, '{1, 32'h0001_FFFC, 0, 0, 1},
        '{1, 32'h0002_0000, 0, 0, 0}, '{1, 32'h0000_FFFC, 0, 0, 0},
        '{1, 32'h0001_0040, 0, 1, 1}, '{0, 32'h0001_0004, 1, 0, 1}};
    plbs_plb_slave dut (.*);
    plbs_core_model u_core (.*);
    initial forever #20 clk = ~clk;
    initial forever #24 link_clk = ~link_clk;
    initial begin
        #200000 errors++;
        end_sim();
    end
    task automatic end_sim;
        if (errors == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rst;
        resetn <= 0;
        link_resetn <= 0;
        repeat (4) @(posedge clk);
        resetn <= 1;
        link_resetn <= 1;
    endtask
    task automatic plb(input logic rw, logic [31:0] a, logic [3:0] sz, logic ign, ack);
        int n = 0;
        plb_req <= '{pavalid: 1, rnw: rw, abus: a, size: sz, be: 4'hF, wrdbus: ~a, uabus: {32{ign}},
                     savalid: ign, abort: ign, buslock: ign, reqpri: {2{ign}}, default: '0};
        do begin
            @(posedge clk);
            n++;
        end while (plb_rsp.addrack !== 1'b1 && n < 20);
        plb_req.pavalid <= 0;
        check(plb_rsp.addrack, ack);
        if (ack) begin
            do @(posedge clk); while (plb_rsp.wrcomp !== 1'b1 && plb_rsp.rdcomp !== 1'b1);
            check({plb_rsp.rdcomp, plb_rsp.wrcomp}, {rw, !rw});
            if (rw) check(plb_rsp.rddbus, ~a);
        end else @(posedge clk);
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
        do @(posedge clk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1));
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        check(s_axi_bresp, 2'h0);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] m, d, input logic [1:0] r);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        check({s_axi_rdata & m, s_axi_rresp}, {d, r});
    endtask
    initial begin
        rst();
        foreach (rows[i]) plb(rows[i].rw, rows[i].a, rows[i].sz, rows[i].ign, rows[i].ack);
        axr(8'h08, 32'hFFFF_FFFF, 32'h0000_0004, 2'h0);
        axr(8'h04, 32'h0000_0700, 32'h0000_0100, 2'h0);
        axw(8'h04, 32'h0000_0700);
        axr(8'h04, 32'h0000_0700, 32'h0000_0000, 2'h0);
        axr(8'h10, 32'hFFFF_FFFF, 32'h0000_0000, 2'h2);
        axw(8'h00, 32'h0000_0000);
        plb(1'b1, 32'h0001_0008, 4'h0, 1'b0, 1'b0);
        axw(8'h00, 32'h0000_0001);
        slow <= 4'hF;
        plb(1'b1, 32'h0001_000C, 4'h0, 1'b0, 1'b1);
        core_irq <= 1;
        repeat (4) @(posedge clk);
        check(host_interrupt_out, 1'b1);
        rst();
        check(sl_mbusy, 1'b0);
        axr(8'h08, 32'hFFFF_FFFF, 32'h0000_0000, 2'h0);
        end_sim();
    end
endmodule
